// ===== inc/swl_pkg.sv
package swl_pkg;

    // APB map, byte addresses
    localparam logic [7:0] SWL_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] SWL_ADDR_STATUS = 8'h04;
    localparam logic [7:0] SWL_ADDR_MAIN   = 8'h08;
    localparam logic [7:0] SWL_ADDR_PUMP   = 8'h0C;
    localparam logic [7:0] SWL_ADDR_AUX    = 8'h10;
    localparam logic [7:0] SWL_ADDR_REF    = 8'h14;
    localparam logic [7:0] SWL_ADDR_MISC   = 8'h18;
    localparam logic [7:0] SWL_ADDR_TEST   = 8'h1C;
    localparam logic [7:0] SWL_ADDR_SHIFT  = 8'h20;

    localparam int         SWL_CTRL_EN_BIT = 0;
    localparam logic       SWL_CTRL_EN_RST = 1'b1;

    // Serial word geometry
    localparam int         SWL_WORD_W      = 24;
    localparam int         SWL_ADDR_W      = 4;

    // Four-bit address codes; bit 0 set alone selects the main divider word
    localparam logic [3:0] SWL_SEL_MISC    = 4'h2;
    localparam logic [3:0] SWL_SEL_REF     = 4'h4;
    localparam logic [3:0] SWL_SEL_AUX     = 4'h6;
    localparam logic [3:0] SWL_SEL_PUMP    = 4'h8;
    localparam logic [3:0] SWL_SEL_TEST    = 4'hA;

    localparam logic [23:0] SWL_WORD_RST   = 24'h000000;
    localparam logic [7:0]  SWL_CNT_RST    = 8'h00;

    typedef enum logic [5:0] {
        SWL_DEST_NONE = 6'b000001,
        SWL_DEST_MAIN = 6'b000010,
        SWL_DEST_PUMP = 6'b000100,
        SWL_DEST_AUX  = 6'b001000,
        SWL_DEST_REF  = 6'b010000,
        SWL_DEST_MISC = 6'b100000
    } swl_dest_e;

    typedef enum logic [2:0] {
        SWL_SLEEP    = 3'b001,
        SWL_STANDBY  = 3'b010,
        SWL_TRANSMIT = 3'b100
    } swl_mode_e;

    typedef struct packed {
        logic [22:0] ratio;
        logic        sel;
    } swl_main_word_s;

    typedef struct packed {
        logic [9:0] spare;
        logic [1:0] divider_modulus_type;
        logic [7:0] main_pump_current;
        logic [3:0] addr;
    } swl_pump_word_s;

    typedef struct packed {
        logic [4:0]  spare;
        logic        aux_divider_enable;
        logic [12:0] aux_divider_ratio;
        logic        enhanced_program_select;
        logic [3:0]  addr;
    } swl_aux_word_s;

    typedef struct packed {
        logic [2:0]  spare;
        logic        main_divider_enable;
        logic [1:0]  aux_ref_postscale;
        logic [1:0]  main_ref_postscale;
        logic [11:0] reference_ratio;
        logic [3:0]  addr;
    } swl_ref_word_s;

    typedef struct packed {
        logic [7:0] spare;
        logic       sleep_control;
        logic       op_mode;
        logic       tx_shift_loop_on;
        logic [1:0] offset_ratio;
        logic [6:0] power_code;
        logic [3:0] addr;
    } swl_misc_word_s;

    typedef struct packed {
        logic master_clock;
        logic ref_buffer;
        logic main_synth;
        logic aux_synth;
        logic tx_path;
    } swl_func_en_s;

    localparam swl_func_en_s SWL_FUNC_RST = 5'b00000;

    function automatic swl_dest_e swl_dest_of(input logic [23:0] word);
        swl_dest_e d;
        d = SWL_DEST_NONE;
        if (word[0]) begin
            d = SWL_DEST_MAIN;
        end else begin
            unique case (word[3:0])
                SWL_SEL_MISC: d = SWL_DEST_MISC;
                SWL_SEL_REF:  d = SWL_DEST_REF;
                SWL_SEL_AUX:  d = SWL_DEST_AUX;
                SWL_SEL_PUMP: d = SWL_DEST_PUMP;
                default:      d = SWL_DEST_NONE;
            endcase
        end
        return d;
    endfunction

    // Two-bit postscaler select to divide value 1, 2, 4 or 8
    function automatic logic [3:0] swl_postscale(input logic [1:0] sel);
        logic [3:0] v;
        v = 4'h1;
        unique case (sel)
            2'h0: v = 4'h1;
            2'h1: v = 4'h2;
            2'h2: v = 4'h4;
            2'h3: v = 4'h8;
        endcase
        return v;
    endfunction

endpackage

// ===== src/swl_sync.sv
`timescale 1ns/100ps
module swl_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ===== src/swl_serial_loader.sv
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
module swl_serial_loader (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  serial_clk,
    input  wire logic                  serial_data,
    input  wire logic                  latch_pulse,
    input  wire logic                  main_sync,
    output logic      [22:0]           main_divider_ratio,
    output logic      [7:0]            main_pump_current,
    output logic      [1:0]            divider_modulus_type,
    output logic                       two_modulus_prescaler,
    output logic      [12:0]           aux_divider_ratio,
    output logic                       enhanced_program_select,
    output logic      [11:0]           reference_ratio,
    output logic      [3:0]            main_ref_divide,
    output logic      [3:0]            aux_ref_divide,
    output logic      [6:0]            power_code,
    output logic      [1:0]            offset_ratio,
    output logic                       digital_mode,
    output swl_pkg::swl_mode_e         power_mode,
    output swl_pkg::swl_func_en_s      func_en
);

    // Link lines and their edges
    logic [3:0]               sync_bus;
    logic                     s_clk;
    logic                     s_data;
    logic                     s_latch;
    logic                     s_msync;
    logic                     sclk_d_reg;
    logic                     latch_d_reg;
    logic                     sclk_rise;
    logic                     latch_rise;
    logic [23:0]              shift_reg;
    logic                     ctrl_en_reg;
    logic                     load_word;
    swl_pkg::swl_dest_e       dest;
    logic                     is_test;
    logic                     apply_main;
    // Main word staging and word registers
    logic                     main_pending_reg;
    logic [22:0]              main_hold_reg;
    logic [22:0]              main_ratio_reg;
    swl_pkg::swl_pump_word_s  pump_tmp_reg;
    swl_pkg::swl_pump_word_s  pump_work_reg;
    swl_pkg::swl_aux_word_s   aux_reg;
    swl_pkg::swl_ref_word_s   ref_reg;
    swl_pkg::swl_misc_word_s  misc_reg;
    logic [23:0]              test_reg;
    logic [7:0]               load_cnt_reg;
    // Mode decode and bus side
    swl_pkg::swl_mode_e       mode_next;
    swl_pkg::swl_func_en_s    func_next;
    logic                     setup_ph;
    logic                     wr_take;
    logic [31:0]              rd_next;
    logic                     err_next;

    // Latch enters inverted: a cleared flop equals its idle high level
    swl_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({main_sync,
                    ~latch_pulse,
                    serial_data,
                    serial_clk}),
        .sync_out (sync_bus)
    );

    assign s_clk   = sync_bus[0];
    assign s_data  = sync_bus[1];
    assign s_latch = ~sync_bus[2];
    assign s_msync = sync_bus[3];

    // Edge detection on the synchronised link lines
    // Latch history starts high, so reset brings no false load
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d_reg  <= 1'b0;
            latch_d_reg <= 1'b1;
        end else begin
            sclk_d_reg  <= s_clk;
            latch_d_reg <= s_latch;
        end
    end

    assign sclk_rise  = s_clk & ~sclk_d_reg;
    assign latch_rise = s_latch & ~latch_d_reg;

    // Shift register, first bit sent ends up as the MSB
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_reg <= swl_pkg::SWL_WORD_RST;
        end else if (!s_latch && sclk_rise) begin
            shift_reg <= {shift_reg[22:0], s_data};
        end
    end

    // A disabled port drops the word; shifting carries on
    assign load_word = latch_rise & ctrl_en_reg;
    assign dest      = swl_pkg::swl_dest_of(shift_reg);
    assign is_test   = ~shift_reg[0] && (shift_reg[3:0] == swl_pkg::SWL_SEL_TEST);

    // Main divider word waits for the divider sync before it takes effect
    assign apply_main = main_pending_reg & s_msync;

    // A newer main word overwrites a pending one; load wins
    always_ff @(posedge clk) begin
        if (rst) begin
            main_hold_reg    <= 23'h000000;
            main_pending_reg <= 1'b0;
        end else begin
            if (load_word && dest == swl_pkg::SWL_DEST_MAIN) begin
                main_hold_reg    <= shift_reg[23:1];
                main_pending_reg <= 1'b1;
            end else if (apply_main) begin
                main_pending_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            main_ratio_reg <= 23'h000000;
            pump_work_reg  <= swl_pkg::SWL_WORD_RST;
        // Staged pump fields move with the main word
        end else if (apply_main) begin
            main_ratio_reg <= main_hold_reg;
            pump_work_reg  <= pump_tmp_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pump_tmp_reg <= swl_pkg::SWL_WORD_RST;
        end else if (load_word && dest == swl_pkg::SWL_DEST_PUMP) begin
            pump_tmp_reg <= shift_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aux_reg <= swl_pkg::SWL_WORD_RST;
        end else if (load_word && dest == swl_pkg::SWL_DEST_AUX) begin
            aux_reg <= shift_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_reg <= swl_pkg::SWL_WORD_RST;
        end else if (load_word && dest == swl_pkg::SWL_DEST_REF) begin
            ref_reg <= shift_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            misc_reg <= swl_pkg::SWL_WORD_RST;
        end else if (load_word && dest == swl_pkg::SWL_DEST_MISC) begin
            misc_reg <= shift_reg;
        end
    end

    // Test word has no effect on the block; a reference load wipes it
    always_ff @(posedge clk) begin
        if (rst) begin
            test_reg <= swl_pkg::SWL_WORD_RST;
        end else if (load_word && dest == swl_pkg::SWL_DEST_REF) begin
            test_reg <= swl_pkg::SWL_WORD_RST;
        end else if (load_word && is_test) begin
            test_reg <= shift_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            load_cnt_reg <= swl_pkg::SWL_CNT_RST;
        end else if (load_word && (dest != swl_pkg::SWL_DEST_NONE || is_test)) begin
            // Accepted words for software; wraps after 255
            load_cnt_reg <= load_cnt_reg + 8'h01;
        end
    end

    // Power mode from the four mode bits; unlisted codes fall back to sleep
    always_comb begin
        mode_next = swl_pkg::SWL_SLEEP;
        if (!misc_reg.sleep_control) begin
            mode_next = swl_pkg::SWL_SLEEP;
        end else if (misc_reg.tx_shift_loop_on && aux_reg.aux_divider_enable
                     && ref_reg.main_divider_enable) begin
            mode_next = swl_pkg::SWL_TRANSMIT;
        end else if (!misc_reg.tx_shift_loop_on && aux_reg.aux_divider_enable
                     && ref_reg.main_divider_enable) begin
            mode_next = swl_pkg::SWL_STANDBY;
        end
    end

    always_comb begin
        func_next = swl_pkg::SWL_FUNC_RST;
        unique case (mode_next)
            swl_pkg::SWL_SLEEP: begin
                func_next.master_clock = 1'b1;
            end
            swl_pkg::SWL_STANDBY: begin
                func_next.master_clock = 1'b1;
                func_next.main_synth   = 1'b1;
                func_next.aux_synth    = 1'b1;
            end
            swl_pkg::SWL_TRANSMIT: begin
                func_next.master_clock = 1'b1;
                func_next.main_synth   = 1'b1;
                func_next.aux_synth    = 1'b1;
                func_next.tx_path      = 1'b1;
            end
        endcase
        // Undefined codes fall to sleep, buffer off there too
        func_next.ref_buffer = (mode_next != swl_pkg::SWL_SLEEP)
                               && (aux_reg.aux_divider_enable
                                   || ref_reg.main_divider_enable);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            power_mode <= swl_pkg::SWL_SLEEP;
            func_en    <= swl_pkg::SWL_FUNC_RST;
        end else begin
            power_mode <= mode_next;
            func_en    <= func_next;
        end
    end

    // Decoded configuration outputs, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            main_divider_ratio      <= 23'h000000;
            main_pump_current       <= 8'h00;
            divider_modulus_type    <= 2'h0;
            two_modulus_prescaler   <= 1'b0;
            aux_divider_ratio       <= 13'h0000;
            enhanced_program_select <= 1'b0;
            reference_ratio         <= 12'h000;
            main_ref_divide         <= 4'h1;
            aux_ref_divide          <= 4'h1;
            power_code              <= 7'h00;
            offset_ratio            <= 2'h0;
            digital_mode            <= 1'b0;
        end else begin
            main_divider_ratio      <= main_ratio_reg;
            main_pump_current       <= pump_work_reg.main_pump_current;
            divider_modulus_type    <= pump_work_reg.divider_modulus_type;
            two_modulus_prescaler   <= pump_work_reg.divider_modulus_type[0];
            aux_divider_ratio       <= aux_reg.aux_divider_ratio;
            enhanced_program_select <= aux_reg.enhanced_program_select;
            reference_ratio         <= ref_reg.reference_ratio;
            main_ref_divide         <= swl_pkg::swl_postscale(ref_reg.main_ref_postscale);
            aux_ref_divide          <= swl_pkg::swl_postscale(ref_reg.aux_ref_postscale);
            power_code              <= misc_reg.power_code;
            offset_ratio            <= misc_reg.offset_ratio;
            digital_mode            <= misc_reg.op_mode;
        end
    end

    // APB slave: answer one cycle into the access phase
    // Fixed timing, no wait states; pready stands one cycle
    assign setup_ph = psel & ~penable;
    assign wr_take  = psel & penable & pready & pwrite;

    always_ff @(posedge clk) begin
        if (rst) begin
            // Port enabled out of reset, no bus write needed
            ctrl_en_reg <= swl_pkg::SWL_CTRL_EN_RST;
        end else if (wr_take && paddr == swl_pkg::SWL_ADDR_CTRL) begin
            ctrl_en_reg <= pwdata[swl_pkg::SWL_CTRL_EN_BIT];
        end
    end

    always_comb begin
        rd_next  = 32'h00000000;
        err_next = 1'b0;
        unique case (paddr)
            swl_pkg::SWL_ADDR_CTRL:   rd_next = {31'h00000000, ctrl_en_reg};
            swl_pkg::SWL_ADDR_STATUS: rd_next = {16'h0000, load_cnt_reg, 4'h0,
                                                 main_pending_reg, power_mode};
            swl_pkg::SWL_ADDR_MAIN:   rd_next = {9'h000, main_ratio_reg};
            swl_pkg::SWL_ADDR_PUMP:   rd_next = {8'h00, pump_work_reg};
            swl_pkg::SWL_ADDR_AUX:    rd_next = {8'h00, aux_reg};
            swl_pkg::SWL_ADDR_REF:    rd_next = {8'h00, ref_reg};
            swl_pkg::SWL_ADDR_MISC:   rd_next = {8'h00, misc_reg};
            swl_pkg::SWL_ADDR_TEST:   rd_next = {8'h00, test_reg};
            swl_pkg::SWL_ADDR_SHIFT:  rd_next = {8'h00, shift_reg};
            // Unmapped offsets give slave error and zero data
            default:                  err_next = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            // Read data only in the answering cycle
            prdata  <= (setup_ph && !pwrite) ? rd_next : 32'h00000000;
            pslverr <= setup_ph & err_next;
        end
    end

endmodule

// ===== testbench/swl_host_model.sv
`timescale 1ns/100ps
module swl_host_model (
    input  wire logic clk,
    output logic      serial_clk,
    output logic      serial_data,
    output logic      latch_pulse
);
    initial begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        latch_pulse = 1'b1;
    end

    // Half of the 160 ns link period
    task automatic half();
        repeat (8) @(posedge clk);
    endtask

    // Link clock stands still between words; data is flipped before the latch is released
    task automatic send_word(input logic [23:0] w);
        latch_pulse <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serial_data <= w[i];
            half();
            serial_clk <= 1'b1;
            half();
            serial_clk <= 1'b0;
        end
        serial_data <= ~w[0];
        half();
        latch_pulse <= 1'b1;
        half();
    endtask
endmodule

// ===== testbench/swl_serial_loader_chk.sv
`timescale 1ns/100ps
module swl_serial_loader_chk (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic                  latch_pulse,
    input wire logic                  main_sync,
    input wire logic [22:0]           main_divider_ratio,
    input wire logic [7:0]            main_pump_current,
    input wire logic [1:0]            divider_modulus_type,
    input wire logic                  two_modulus_prescaler,
    input wire logic [12:0]           aux_divider_ratio,
    input wire logic [11:0]           reference_ratio,
    input wire logic [3:0]            main_ref_divide,
    input wire logic [3:0]            aux_ref_divide,
    input wire logic [6:0]            power_code,
    input wire swl_pkg::swl_mode_e    power_mode,
    input wire swl_pkg::swl_func_en_s func_en
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence settled(m);
        (power_mode == m && !rst) [*2];
    endsequence

    chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    chk_postscale_code: assert property (
        main_ref_divide inside {4'h1, 4'h2, 4'h4, 4'h8} &&
        aux_ref_divide inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("postscale divide outside 1, 2, 4, 8");
    chk_prescaler_type: assert property (
        $stable(divider_modulus_type) [*2] |->
        two_modulus_prescaler == divider_modulus_type[0])
        else $error("prescaler type does not follow modulus low bit");
    chk_sleep_funcs: assert property (
        settled(swl_pkg::SWL_SLEEP) |-> func_en == 5'b10000)
        else $error("sleep enables more than master clock");
    chk_standby_funcs: assert property (
        settled(swl_pkg::SWL_STANDBY) |-> func_en == 5'b11110)
        else $error("standby enables wrong");
    chk_transmit_funcs: assert property (
        settled(swl_pkg::SWL_TRANSMIT) |-> func_en == 5'b11111)
        else $error("transmit does not enable all");
    chk_mode_legal: assert property (
        power_mode inside {swl_pkg::SWL_SLEEP, swl_pkg::SWL_STANDBY,
                           swl_pkg::SWL_TRANSMIT})
        else $error("power mode code illegal");
    chk_main_hold: assert property (
        !main_sync [*6] |-> $stable(main_divider_ratio) &&
        $stable(main_pump_current) && $stable(divider_modulus_type))
        else $error("main working values moved without sync");
    chk_shift_quiet: assert property (
        !latch_pulse [*6] |-> $stable(power_code) &&
        $stable(reference_ratio) && $stable(aux_divider_ratio))
        else $error("word outputs moved while shifting");
endmodule

bind swl_serial_loader swl_serial_loader_chk u_chk (
    .clk, .rst, .psel, .penable, .pready, .latch_pulse, .main_sync,
    .main_divider_ratio, .main_pump_current, .divider_modulus_type,
    .two_modulus_prescaler, .aux_divider_ratio, .reference_ratio,
    .main_ref_divide, .aux_ref_divide, .power_code, .power_mode, .func_en
);

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [23:0] word;
        logic [7:0]  ra;
        logic [3:0]  sel;
        logic [15:0] exp;
    } swl_row_s;
    localparam logic [7:0] A_MI = swl_pkg::SWL_ADDR_MISC;
    localparam logic [7:0] A_RF = swl_pkg::SWL_ADDR_REF;
    localparam logic [7:0] A_AX = swl_pkg::SWL_ADDR_AUX;
    localparam swl_row_s ROWS [13] = '{
        '{24'h00D552, A_MI, 4'h0, 16'h0055}, '{24'h00F552, A_MI, 4'h1, 16'h0002},
        '{24'h00D552, A_MI, 4'h2, 16'h0001}, '{24'h001552, A_MI, 4'h2, 16'h0000},
        '{24'h1CABC4, A_RF, 4'h4, 16'h0001}, '{24'h19ABC4, A_RF, 4'h4, 16'h0002},
        '{24'h16ABC4, A_RF, 4'h4, 16'h0004}, '{24'h13ABC4, A_RF, 4'h4, 16'h0008},
        '{24'h1CABC4, A_RF, 4'h5, 16'h0008}, '{24'h10ABC4, A_RF, 4'h3, 16'h0ABC},
        '{24'h07FFF6, A_AX, 4'h7, 16'h0001}, '{24'h07FFE6, A_AX, 4'h6, 16'h1FFF},
        '{24'h0400A6, A_AX, 4'h7, 16'h0000}};
    localparam logic [23:0] PROG [5] = '{24'h000552, 24'h10ABC4, 24'h07FFE6,
                                         24'h001A58, 24'h555555};
    localparam logic [23:0] M_MISC [4] = '{24'h000552, 24'h008552, 24'h00A552, 24'h00A552};
    localparam logic [23:0] M_AUX [4] = '{24'h07FFE6, 24'h07FFE6, 24'h07FFE6, 24'h03FFE6};
    // Expected {power_mode, func_en}
    localparam logic [7:0] M_EXP [4] = '{8'h30, 8'h5E, 8'h9F, 8'h30};

    logic clk, rst, psel, penable, pwrite, pready, pslverr, main_sync;
    logic serial_clk, serial_data, latch_pulse, two_modulus_prescaler;
    logic enhanced_program_select, digital_mode, er;
    logic [7:0] paddr, main_pump_current;
    logic [31:0] pwdata, prdata, rd;
    logic [22:0] main_divider_ratio;
    logic [1:0] divider_modulus_type, offset_ratio;
    logic [12:0] aux_divider_ratio;
    logic [11:0] reference_ratio;
    logic [3:0] main_ref_divide, aux_ref_divide;
    logic [6:0] power_code;
    swl_pkg::swl_mode_e power_mode;
    swl_pkg::swl_func_en_s func_en;
    int num_errors = 0;
    int checks_done = 0;

    swl_serial_loader u_dut (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .serial_clk, .serial_data, .latch_pulse, .main_sync,
        .main_divider_ratio, .main_pump_current, .divider_modulus_type,
        .two_modulus_prescaler, .aux_divider_ratio, .enhanced_program_select,
        .reference_ratio, .main_ref_divide, .aux_ref_divide, .power_code,
        .offset_ratio, .digital_mode, .power_mode, .func_en);
    swl_host_model u_host (.clk, .serial_clk, .serial_data, .latch_pulse);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'(pready), 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse_sync();
        for (int k = 1; k >= 0; k--) begin
            main_sync <= k[0];
            repeat (8) @(posedge clk);
        end
    endtask

    function automatic logic [31:0] pick(input logic [3:0] s);
        case (s)
            4'h0: return 32'(power_code);
            4'h1: return 32'(offset_ratio);
            4'h2: return 32'(digital_mode);
            4'h3: return 32'(reference_ratio);
            4'h4: return 32'(main_ref_divide);
            4'h5: return 32'(aux_ref_divide);
            4'h6: return 32'(aux_divider_ratio);
            default: return 32'(enhanced_program_select);
        endcase
    endfunction

    task automatic tally_and_finish();
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        main_sync = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset mode", 32'({power_mode, func_en}), 32'h30);
        chk("reset divide", 32'(main_ref_divide), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        foreach (ROWS[i]) begin
            u_host.send_word(ROWS[i].word);
            apb(1'b0, ROWS[i].ra, 32'h0);
            chk("word reg", rd, {8'h00, ROWS[i].word});
            chk("field", pick(ROWS[i].sel), 32'(ROWS[i].exp));
        end
        foreach (PROG[i]) u_host.send_word(PROG[i]);
        chk("main held", 32'({main_divider_ratio, main_pump_current}), 32'h0);
        pulse_sync();
        chk("main", 32'(main_divider_ratio), 32'h2AAAAA);
        chk("pump", 32'({main_pump_current, divider_modulus_type, two_modulus_prescaler}),
            32'h52B);
        u_host.send_word(24'h000003);
        u_host.send_word(24'h002A58);
        chk("main wait", 32'(main_divider_ratio), 32'h2AAAAA);
        pulse_sync();
        chk("main 2", 32'(main_divider_ratio), 32'h1);
        chk("pump 2", 32'({main_pump_current, divider_modulus_type, two_modulus_prescaler}),
            32'h52C);
        u_host.send_word(24'hFFFFFC);
        apb(1'b0, swl_pkg::SWL_ADDR_SHIFT, 32'h0);
        chk("shift", rd, 32'hFFFFFC);
        chk("discard", {power_code, reference_ratio, aux_divider_ratio},
            {7'h55, 12'hABC, 13'h1FFF});
        u_host.send_word(24'h00005A);
        apb(1'b0, swl_pkg::SWL_ADDR_TEST, 32'h0);
        chk("test word", rd, 32'h5A);
        u_host.send_word(24'h10ABC4);
        apb(1'b0, swl_pkg::SWL_ADDR_TEST, 32'h0);
        chk("test clear", rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            u_host.send_word(M_AUX[i]);
            u_host.send_word(M_MISC[i]);
            chk("mode", 32'({power_mode, func_en}), 32'(M_EXP[i]));
        end
        apb(1'b1, swl_pkg::SWL_ADDR_CTRL, 32'hFFFFFFFE);
        u_host.send_word(24'h07FFE6);
        chk("disabled", 32'({power_mode, func_en}), 32'h30);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("mid reset", 32'({power_mode, func_en, main_divider_ratio}), 32'h18000000);
        apb(1'b0, swl_pkg::SWL_ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h1);
        apb(1'b0, swl_pkg::SWL_ADDR_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h1);
        tally_and_finish();
    end
endmodule
